/* design/status_pkg.sv */
// constants and types for the status byte reporting block
//
// How it works
// RQ1: poll bit 0 means no acquisition running
// RQ2: poll bit 1 means no command executing
// RQ3: poll bit 2 flags enabled error bits
// RQ4: poll bit 3 flags enabled measurement bits
// RQ5: poll bit 4 means output buffer non-empty
// RQ6: poll bit 5 flags enabled standard events
// RQ7: poll bit 6 records service request; bit 7 zero
// RQ8: measurement bits 0-2 flag reserve/filter/output overloads
// RQ9: measurement bit 3 flags reference unlock
// RQ10: measurement bit 4 flags 200 Hz crossing
// RQ11: measurement bit 5 flags time constant change
// RQ12: measurement bit 6 flags trigger received
// RQ13: measurement bit 7 flags plot completed
// RQ14: event bit 0 input queue overflow; 1,3 unused
// RQ15: event bit 2 flags output queue overflow
// RQ16: event bit 4 flags command execution failure
// RQ17: event bit 5 flags illegal command
// RQ18: event bit 6 key/knob, bit 7 power-on
// RQ19: error bit 0 print/plot, bit 1 backup
// RQ20: error bits 2,4,6 RAM, ROM, processor test faults
// RQ21: error bits 5,3,7 transfer abort, disk, math
// RQ22: masks written whole or one bit at a time
// RQ23: queries return whole byte or one bit
// RQ24: clear-status clears every status byte together; poll bit 6 stays set if a request is raised in the clearing cycle
// RQ25: power-on-clear setting decides mask wipe at power-up
// RQ26: event bits latch until read or clear-status
// RQ27: enabled poll bits raise a service request
package status_pkg;

  // serial poll byte bit positions
  localparam int SP_ACQ_IDLE = 0;
  localparam int SP_CMD_IDLE = 1;
  localparam int SP_ERR      = 2;
  localparam int SP_MEAS     = 3;
  localparam int SP_MAV      = 4;
  localparam int SP_ESB      = 5;
  localparam int SP_SRQ      = 6;

  // measurement byte bit positions
  localparam int MC_RESERVE  = 0;
  localparam int MC_FILTER   = 1;
  localparam int MC_OUTPUT   = 2;
  localparam int MC_UNLOCK   = 3;
  localparam int MC_RANGE    = 4;
  localparam int MC_TCONST   = 5;
  localparam int MC_TRIG     = 6;
  localparam int MC_PLOT     = 7;

  // standard event byte bit positions
  localparam int SE_INPUT_OVF  = 0;
  localparam int SE_OUTPUT_OVF = 2;
  localparam int SE_EXEC_ERR   = 4;
  localparam int SE_ILLEGAL    = 5;
  localparam int SE_USER_REQ   = 6;
  localparam int SE_POWER_ON   = 7;

  // bits that can ever be set in each event byte, and the poll bits that feed the request
  localparam logic [7:0] STD_USED_MASK = 8'hF5;
  localparam logic [7:0] ALL_USED_MASK = 8'hFF;
  localparam logic [7:0] SRQ_SRC_MASK  = 8'h3F;

  // values after reset
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic       PCLR_RESET    = 1'b1;

  // host command codes
  typedef enum logic [2:0] {
    OP_READ_STATUS = 3'h0,
    OP_READ_MASK   = 3'h1,
    OP_WRITE_MASK  = 3'h2,
    OP_CLEAR       = 3'h3,
    OP_WRITE_PCLR  = 3'h4,
    OP_READ_PCLR   = 3'h5
  } op_t;

  // which byte (and its enable mask) a command addresses
  typedef enum logic [1:0] {
    SEL_SERIAL = 2'h0,
    SEL_MEAS   = 2'h1,
    SEL_STD    = 2'h2,
    SEL_ERR    = 2'h3
  } sel_t;

endpackage : status_pkg

/* design/mask_cmd_if.sv */
// shared write path from the command decoder to the enable masks
`timescale 1ns/10ps
interface mask_cmd_if;
  logic       wr;      // one-cycle write strobe
  logic       bit_en;  // single-bit write when high
  logic [2:0] idx;     // bit index for single-bit write
  logic [7:0] data;    // whole byte, or value in bit 0
  logic       wipe;    // power-up clear of every mask

  modport ctrl (output wr, bit_en, idx, data, wipe);
  modport mask (input  wr, bit_en, idx, data, wipe);
endinterface : mask_cmd_if

/* design/event_latch.sv */
// sticky event byte: bits set by events, cleared by read or clear
`timescale 1ns/10ps
module event_latch #(
  parameter int         W    = 8,
  parameter logic [W-1:0] USED = '1
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  // events and clear
  input  wire logic [W-1:0] set_i,
  input  wire logic         clr_i,
  // latched byte
  output logic      [W-1:0] q_o
);

  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= '0;
    end else begin
      q_o <= (q_o & ~{W{clr_i}}) | (set_i & USED); // see RQ26
    end
  end

endmodule : event_latch

/* design/enable_mask.sv */
// one enable mask, written whole or one bit at a time
`timescale 1ns/10ps
module enable_mask
  import status_pkg::*;
(
  // clock and reset
  input  wire logic  clk_sys_i,
  input  wire logic  rst_n_i,
  // write path
  mask_cmd_if.mask   cmd,
  input  wire logic  sel_i,
  // mask value
  output logic [7:0] q_o
);

  // whole-byte or single-bit update; wipe from power-up has priority
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= MASK_RESET;
    end else if (cmd.wipe) begin
      q_o <= MASK_RESET; // see RQ25
    end else if (cmd.wr && sel_i) begin
      if (cmd.bit_en) begin
        q_o[cmd.idx] <= cmd.data[0]; // see RQ22
      end else begin
        q_o <= cmd.data; // see RQ22
      end
    end
  end

endmodule : enable_mask

/* design/status_reporting.sv */
// status byte reporting: poll summary, event bytes, masks, host commands
`timescale 1ns/10ps
module status_reporting
  import status_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  // instrument state levels
  input  wire logic             acquisition_idle_i,
  input  wire logic             command_idle_i,
  input  wire logic             out_buf_nonempty_i,
  input  wire logic             freq_above_200hz_i,
  // measurement events, one-cycle pulses
  input  wire logic             reserve_overload_i,
  input  wire logic             filter_overload_i,
  input  wire logic             output_overload_i,
  input  wire logic             reference_unlocked_i,
  input  wire logic             time_constant_changed_i,
  input  wire logic             trigger_i,
  input  wire logic             plot_done_i,
  // interface events, one-cycle pulses
  input  wire logic             input_queue_overflow_i,
  input  wire logic             output_queue_overflow_i,
  input  wire logic             execution_error_i,
  input  wire logic             illegal_command_i,
  input  wire logic             user_request_i,
  input  wire logic             power_restore_i,
  // error events, one pulse bit per source
  input  wire logic [7:0]       error_event_i,
  // host command port
  input  wire logic             cmd_valid_i,
  input  wire status_pkg::op_t  cmd_op_i,
  input  wire status_pkg::sel_t cmd_sel_i,
  input  wire logic             cmd_bit_en_i,
  input  wire logic [2:0]       cmd_bit_i,
  input  wire logic [7:0]       cmd_data_i,
  // host answer port
  output logic                  resp_valid_o,
  output logic [7:0]            resp_data_o,
  // service request and setting
  output logic                  srq_o,
  output logic                  power_on_clear_setting_o
);
  import status_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_q;
  logic rst_n;

  // async assert, release after two clock edges
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // command decode

  logic cmd_clear;
  logic cmd_wr_mask;
  logic rd_status;
  logic rd_query;

  assign cmd_clear   = cmd_valid_i && (cmd_op_i == OP_CLEAR);
  assign cmd_wr_mask = cmd_valid_i && (cmd_op_i == OP_WRITE_MASK);
  assign rd_status   = cmd_valid_i && (cmd_op_i == OP_READ_STATUS);
  assign rd_query    = cmd_valid_i && (cmd_op_i == OP_READ_STATUS ||
                       cmd_op_i == OP_READ_MASK ||
                       cmd_op_i == OP_READ_PCLR);

  //////////////////////////////////////////////////////////////////////
  // power-on event and power-on-clear setting

  logic pwr_up_q;   // one pulse after reset release
  logic pclr_q;

  // fires once after release; kept as a flop so reset loads a constant
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_up_q <= 1'b1;
    end else begin
      pwr_up_q <= 1'b0;
    end
  end

  // setting kept across a warm power restore, lost only on nrst_i
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pclr_q <= PCLR_RESET;
    end else if (cmd_valid_i && (cmd_op_i == OP_WRITE_PCLR)) begin
      pclr_q <= cmd_data_i[0]; // see RQ25
    end
  end

  assign power_on_clear_setting_o = pclr_q;

  //////////////////////////////////////////////////////////////////////
  // enable masks

  mask_cmd_if mcmd ();

  // masks are wiped on power restore only when the setting asks
  assign mcmd.wr     = cmd_wr_mask;
  assign mcmd.bit_en = cmd_bit_en_i;
  assign mcmd.idx    = cmd_bit_i;
  assign mcmd.data   = cmd_data_i;
  assign mcmd.wipe   = power_restore_i && pclr_q; // see RQ25

  logic [7:0] sre_mask;
  logic [7:0] meas_mask;
  logic [7:0] std_mask;
  logic [7:0] err_mask;

  enable_mask u_sre_mask (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .cmd       (mcmd.mask),
    .sel_i     (cmd_sel_i == SEL_SERIAL),
    .q_o       (sre_mask)
  );

  enable_mask u_meas_mask (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .cmd       (mcmd.mask),
    .sel_i     (cmd_sel_i == SEL_MEAS),
    .q_o       (meas_mask)
  );

  enable_mask u_std_mask (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .cmd       (mcmd.mask),
    .sel_i     (cmd_sel_i == SEL_STD),
    .q_o       (std_mask)
  );

  enable_mask u_err_mask (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .cmd       (mcmd.mask),
    .sel_i     (cmd_sel_i == SEL_ERR),
    .q_o       (err_mask)
  );

  //////////////////////////////////////////////////////////////////////
  // measurement-condition byte

  logic       range_q;
  logic       range_vld_q;
  logic [7:0] meas_set;
  logic [7:0] meas_q;

  // first sample after reset only arms the detector, no false crossing
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      range_q     <= 1'b0;
      range_vld_q <= 1'b0;
    end else begin
      range_q     <= freq_above_200hz_i;
      range_vld_q <= 1'b1;
    end
  end

  always_comb begin
    meas_set              = 8'h00;
    meas_set[MC_RESERVE]  = reserve_overload_i;      // see RQ8
    meas_set[MC_FILTER]   = filter_overload_i;       // see RQ8
    meas_set[MC_OUTPUT]   = output_overload_i;       // see RQ8
    meas_set[MC_UNLOCK]   = reference_unlocked_i;    // see RQ9
    meas_set[MC_RANGE]    = range_vld_q &&
                            (range_q != freq_above_200hz_i); // see RQ10
    meas_set[MC_TCONST]   = time_constant_changed_i; // see RQ11
    meas_set[MC_TRIG]     = trigger_i;               // see RQ12
    meas_set[MC_PLOT]     = plot_done_i;             // see RQ13
  end

  event_latch #(.W(8), .USED(ALL_USED_MASK)) u_meas (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .set_i     (meas_set),
    .clr_i     (cmd_clear || (rd_status && cmd_sel_i == SEL_MEAS)),
    .q_o       (meas_q)
  );

  //////////////////////////////////////////////////////////////////////
  // standard event byte

  logic [7:0] std_set;
  logic [7:0] std_q;

  // unused bits 1 and 3 are dropped by the latch's used mask
  always_comb begin
    std_set                = 8'h00;
    std_set[SE_INPUT_OVF]  = input_queue_overflow_i;     // see RQ14
    std_set[SE_OUTPUT_OVF] = output_queue_overflow_i;    // see RQ15
    std_set[SE_EXEC_ERR]   = execution_error_i;          // see RQ16
    std_set[SE_ILLEGAL]    = illegal_command_i;          // see RQ17
    std_set[SE_USER_REQ]   = user_request_i;             // see RQ18
    std_set[SE_POWER_ON]   = pwr_up_q || power_restore_i; // see RQ18
  end

  event_latch #(.W(8), .USED(STD_USED_MASK)) u_std (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .set_i     (std_set),
    .clr_i     (cmd_clear || (rd_status && cmd_sel_i == SEL_STD)),
    .q_o       (std_q)
  );

  //////////////////////////////////////////////////////////////////////
  // error byte: sources map one to one onto bits

  logic [7:0] err_q;

  event_latch #(.W(8), .USED(ALL_USED_MASK)) u_err (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .set_i     (error_event_i), // see RQ19 RQ20 RQ21
    .clr_i     (cmd_clear || (rd_status && cmd_sel_i == SEL_ERR)),
    .q_o       (err_q)
  );

  //////////////////////////////////////////////////////////////////////
  // serial poll summary and service request

  logic [7:0] spb;
  logic       srq_q;
  logic       srq_raise;

  always_comb begin
    spb              = 8'h00;                   // bit 7 stays zero, see RQ7
    spb[SP_ACQ_IDLE] = acquisition_idle_i;      // see RQ1
    spb[SP_CMD_IDLE] = command_idle_i;          // see RQ2
    spb[SP_ERR]      = |(err_q & err_mask);     // see RQ3
    spb[SP_MEAS]     = |(meas_q & meas_mask);   // see RQ4
    spb[SP_MAV]      = out_buf_nonempty_i;      // see RQ5
    spb[SP_ESB]      = |(std_q & std_mask);     // see RQ6
    spb[SP_SRQ]      = srq_q;                   // see RQ7
  end

  // the summary bits themselves feed the request, not the stored flag
  assign srq_raise = |(spb & sre_mask & SRQ_SRC_MASK); // see RQ27

  // sticky; a raise in the clearing cycle wins
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      srq_q <= 1'b0;
    end else if (srq_raise) begin
      srq_q <= 1'b1; // see RQ7
    end else if (cmd_clear ||
                 (rd_status && cmd_sel_i == SEL_SERIAL)) begin
      srq_q <= 1'b0; // see RQ24
    end
  end

  assign srq_o = srq_q;

  //////////////////////////////////////////////////////////////////////
  // query answers

  logic [7:0] rd_byte;

  // pick the addressed status byte or mask
  always_comb begin
    rd_byte = 8'h00;
    if (cmd_op_i == OP_READ_PCLR) begin
      rd_byte = {7'h00, pclr_q};
    end else if (cmd_op_i == OP_READ_MASK) begin
      if (cmd_sel_i == SEL_SERIAL) begin
        rd_byte = sre_mask;
      end else if (cmd_sel_i == SEL_MEAS) begin
        rd_byte = meas_mask;
      end else if (cmd_sel_i == SEL_STD) begin
        rd_byte = std_mask;
      end else begin
        rd_byte = err_mask;
      end
    end else if (cmd_sel_i == SEL_SERIAL) begin
      rd_byte = spb;
    end else if (cmd_sel_i == SEL_MEAS) begin
      rd_byte = meas_q;
    end else if (cmd_sel_i == SEL_STD) begin
      rd_byte = std_q;
    end else begin
      rd_byte = err_q;
    end
  end

  // answer one cycle after any query; byte or single bit
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_o <= 1'b0;
      resp_data_o  <= 8'h00;
    end else begin
      resp_valid_o <= rd_query;
      // data held between queries so a late host read still sees it
      if (rd_query && cmd_bit_en_i && cmd_op_i != OP_READ_PCLR) begin
        resp_data_o <= {7'h00, rd_byte[cmd_bit_i]}; // see RQ23
      end else if (rd_query) begin
        resp_data_o <= rd_byte; // see RQ23
      end
    end
  end

endmodule : status_reporting

/* dv/status_reporting_assertions.sv */
// concurrent checks on the status reporting ports
`timescale 1ns/10ps
module status_checker
  import status_pkg::*;
(
  // clock and reset
  input wire logic             clk_sys_i,
  input wire logic             nrst_i,
  // levels and events
  input wire logic             acquisition_idle_i,
  input wire logic             command_idle_i,
  input wire logic             out_buf_nonempty_i,
  input wire logic             illegal_command_i,
  input wire logic [7:0]       error_event_i,
  // host command and answer
  input wire logic             cmd_valid_i,
  input wire status_pkg::op_t  cmd_op_i,
  input wire status_pkg::sel_t cmd_sel_i,
  input wire logic             cmd_bit_en_i,
  input wire logic [7:0]       cmd_data_i,
  input wire logic             resp_valid_o,
  input wire logic [7:0]       resp_data_o
);
  logic rd_any, rd_stat, rd_poll, rd_std, rd_err, rd_mask, wr_mask;
  ////////////////////////////////////////
  // request decode shared by the properties
  assign rd_any  = cmd_valid_i && cmd_op_i inside {OP_READ_STATUS,
                   OP_READ_MASK, OP_READ_PCLR};
  assign rd_stat = cmd_valid_i && cmd_op_i == OP_READ_STATUS
                   && !cmd_bit_en_i;
  assign rd_poll = rd_stat && cmd_sel_i == SEL_SERIAL;
  assign rd_std  = rd_stat && cmd_sel_i == SEL_STD;
  assign rd_err  = rd_stat && cmd_sel_i == SEL_ERR;
  assign rd_mask = cmd_valid_i && cmd_op_i == OP_READ_MASK && !cmd_bit_en_i;
  assign wr_mask = cmd_valid_i && cmd_op_i == OP_WRITE_MASK && !cmd_bit_en_i;
  // one domain; disabled only while nrst_i is low, not during the two-flop release
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////
  answer_time_a: assert property (
    resp_valid_o == $past(rd_any)) else $error("answer strobe wrong");
  poll_acq_a: assert property (
    rd_poll |=> resp_data_o[0] == $past(acquisition_idle_i))
    else $error("poll bit 0 wrong");
  poll_cmd_a: assert property (
    rd_poll |=> resp_data_o[1] == $past(command_idle_i))
    else $error("poll bit 1 wrong");
  poll_mav_a: assert property (
    rd_poll |=> resp_data_o[4] == $past(out_buf_nonempty_i))
    else $error("poll bit 4 wrong");
  poll_spare_a: assert property (
    rd_poll |=> !resp_data_o[7]) else $error("poll bit 7 set");
  std_spare_a: assert property (
    rd_std |=> resp_data_o[1] == 1'b0 && resp_data_o[3] == 1'b0)
    else $error("unused event bit set");
  bit_query_a: assert property (
    cmd_valid_i && cmd_bit_en_i && cmd_op_i == OP_READ_STATUS
    |=> resp_data_o[7:1] == 7'h00) else $error("bit answer too wide");
  read_clears_a: assert property (
    rd_err && !(|error_event_i) ##1 rd_err |=> resp_data_o == 8'h00)
    else $error("error byte kept after read");
  event_sticks_a: assert property (
    illegal_command_i ##1 !cmd_valid_i ##1 rd_std |=> resp_data_o[5])
    else $error("illegal command not latched");
  mask_store_a: assert property (
    wr_mask ##1 (rd_mask && cmd_sel_i == $past(cmd_sel_i))
    |=> resp_data_o == $past(cmd_data_i, 2)) else $error("mask lost");
  // main scenarios reached
  cover property (rd_poll ##1 resp_valid_o);
  cover property (wr_mask ##1 rd_mask);
  cover property (illegal_command_i ##2 rd_std);
endmodule : status_checker
////////////////////////////////////////
bind status_reporting status_checker u_chk (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
  .acquisition_idle_i(acquisition_idle_i),
  .command_idle_i(command_idle_i),
  .out_buf_nonempty_i(out_buf_nonempty_i),
  .illegal_command_i(illegal_command_i),
  .error_event_i(error_event_i), .cmd_valid_i(cmd_valid_i),
  .cmd_op_i(cmd_op_i), .cmd_sel_i(cmd_sel_i),
  .cmd_bit_en_i(cmd_bit_en_i), .cmd_data_i(cmd_data_i),
  .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o)
);

/* dv/host_model.sv */
// host controller model driving the command port
`timescale 1ns/10ps
module host_model
  import status_pkg::*;
(
  // clock
  input  wire logic             clk_sys_i,
  // command side
  output logic                  cmd_valid_o,
  output status_pkg::op_t       cmd_op_o,
  output status_pkg::sel_t      cmd_sel_o,
  output logic                  cmd_bit_en_o,
  output logic [2:0]            cmd_bit_o,
  output logic [7:0]            cmd_data_o,
  // answer side
  input  wire logic             resp_valid_i,
  input  wire logic [7:0]       resp_data_i
);
  ////////////////////////////////////////
  // quiet port before the first edge
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = OP_READ_STATUS;
    cmd_sel_o = SEL_SERIAL;
    cmd_bit_en_o = 1'b0;
    cmd_bit_o = 3'h0;
    cmd_data_o = 8'h00;
  end
  // one request per edge; back to back calls keep valid high
  task automatic send(input op_t op, input sel_t s, input logic be,
                      input logic [2:0] b, input logic [7:0] d);
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b1;
    cmd_op_o <= op;
    cmd_sel_o <= s;
    cmd_bit_en_o <= be;
    cmd_bit_o <= b;
    cmd_data_o <= d;
  endtask : send
  // release scrambles data so a stale byte is never reused
  task automatic query(input op_t op, input sel_t s, input logic be,
                       input logic [2:0] b, input logic [7:0] d,
                       output logic [7:0] r, output logic v);
    send(op, s, be, b, d);
    @(posedge clk_sys_i);
    cmd_valid_o <= 1'b0;
    cmd_data_o <= ~d;
    #1;
    v = resp_valid_i;
    r = resp_data_i;
  endtask : query
endmodule : host_model

/* dv/status_reporting_test.sv */
// self-checking bench for the status reporting block
`timescale 1ns/10ps
module status_reporting_test;
  import status_pkg::*;
  typedef struct packed {sel_t s; logic [7:0] used;} row_t;
  logic       clk_sys_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic       acq = 1'b0, cidle = 1'b0, mav = 1'b0, fhi = 1'b0;
  logic [7:0] mev = 8'h00, sev = 8'h00, eev = 8'h00;
  logic       cmd_valid, cmd_be, resp_valid, srq, pclr;
  op_t        cmd_op;
  sel_t       cmd_sel;
  logic [2:0] cmd_bit;
  logic [7:0] cmd_data, resp_data;
  int         err_count = 0, comparisons = 0;
  row_t       rows [3] = '{'{SEL_MEAS, 8'hEF}, '{SEL_STD, 8'hF5},
                           '{SEL_ERR, 8'hFF}};
  ////////////////////////////////////////
  status_reporting dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .acquisition_idle_i(acq), .command_idle_i(cidle),
    .out_buf_nonempty_i(mav), .freq_above_200hz_i(fhi),
    .reserve_overload_i(mev[0]), .filter_overload_i(mev[1]),
    .output_overload_i(mev[2]), .reference_unlocked_i(mev[3]),
    .time_constant_changed_i(mev[5]), .trigger_i(mev[6]),
    .plot_done_i(mev[7]), .input_queue_overflow_i(sev[0]),
    .output_queue_overflow_i(sev[2]), .execution_error_i(sev[4]),
    .illegal_command_i(sev[5]), .user_request_i(sev[6]),
    .power_restore_i(sev[7]), .error_event_i(eev),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_sel_i(cmd_sel),
    .cmd_bit_en_i(cmd_be), .cmd_bit_i(cmd_bit), .cmd_data_i(cmd_data),
    .resp_valid_o(resp_valid), .resp_data_o(resp_data),
    .srq_o(srq), .power_on_clear_setting_o(pclr));
  host_model host (
    .clk_sys_i(clk_sys_i), .cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op),
    .cmd_sel_o(cmd_sel), .cmd_bit_en_o(cmd_be), .cmd_bit_o(cmd_bit),
    .cmd_data_o(cmd_data), .resp_valid_i(resp_valid),
    .resp_data_i(resp_data));
  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  // one-cycle event pulse on the chosen byte's source
  task automatic pulse(input sel_t s, input int b);
    @(posedge clk_sys_i);
    case (s)
      SEL_MEAS: mev[b] <= 1'b1;
      SEL_STD: sev[b] <= 1'b1;
      default: eev[b] <= 1'b1;
    endcase
    @(posedge clk_sys_i);
    mev <= 8'h00;
    sev <= 8'h00;
    eev <= 8'h00;
  endtask : pulse
  // answer expected only for the three read codes
  task automatic ask(input op_t op, input sel_t s, input logic be,
                     input logic [2:0] b, input logic [7:0] e);
    logic [7:0] r;
    logic       v;
    logic       rd;
    rd = op inside {OP_READ_STATUS, OP_READ_MASK, OP_READ_PCLR};
    host.query(op, s, be, b, 8'h00, r, v);
    chk1(v, rd);
    if (rd) chk8(r, e);
  endtask : ask
  task automatic wrap_up();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // hang guard, far beyond the few hundred cycles used
  initial begin
    #50000;
    err_count++;
    wrap_up();
  end
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    ask(OP_READ_STATUS, SEL_STD, 1'b0, 3'h0, 8'h80);
    ask(OP_READ_PCLR, SEL_SERIAL, 1'b0, 3'h0, 8'h01);
    for (int i = 0; i < 4; i++) ask(OP_READ_MASK, sel_t'(i), 0, 0, 0);
    // each used bit alone, then gone after its read
    foreach (rows[i]) for (int b = 0; b < 8; b++) if (rows[i].used[b]) begin
      pulse(rows[i].s, b);
      ask(OP_READ_STATUS, rows[i].s, 1'b0, 3'h0, 8'h01 << b);
      ask(OP_READ_STATUS, rows[i].s, 1'b0, 3'h0, 8'h00);
    end
    // live poll bits, swapped levels catch mav crossed with acq or cidle
    @(posedge clk_sys_i) {acq, cidle, mav} <= 3'b110;
    ask(OP_READ_STATUS, SEL_SERIAL, 0, 0, 8'h03);
    @(posedge clk_sys_i) {acq, cidle, mav} <= 3'b001;
    ask(OP_READ_STATUS, SEL_SERIAL, 0, 0, 8'h10);
    ask(OP_READ_STATUS, SEL_SERIAL, 1, 3'h4, 8'h01);
    ask(OP_READ_STATUS, SEL_SERIAL, 1, 3'h0, 8'h00);
    @(posedge clk_sys_i) mav <= 1'b0;
    // masks written whole and bitwise, back to back
    host.send(OP_WRITE_MASK, SEL_MEAS, 0, 0, 8'h80);
    host.send(OP_WRITE_MASK, SEL_MEAS, 1, 3'h3, 8'h01);
    ask(OP_READ_MASK, SEL_MEAS, 0, 0, 8'h88);
    host.send(OP_WRITE_MASK, SEL_MEAS, 1, 3'h7, 8'h00);
    ask(OP_READ_MASK, SEL_MEAS, 0, 0, 8'h08);
    host.send(OP_WRITE_MASK, SEL_ERR, 0, 0, 8'h04);
    ask(OP_READ_MASK, SEL_ERR, 0, 0, 8'h04);
    host.send(OP_WRITE_MASK, SEL_STD, 0, 0, 8'h20);
    host.send(OP_WRITE_MASK, SEL_SERIAL, 0, 0, 8'h2C);
    ask(OP_READ_MASK, SEL_SERIAL, 0, 0, 8'h2C);
    // enabled events fold into summary bits and raise a request
    pulse(SEL_MEAS, 3);
    pulse(SEL_STD, 5);
    pulse(SEL_ERR, 2);
    repeat (2) @(posedge clk_sys_i);
    #1 chk1(srq, 1'b1);
    ask(OP_READ_STATUS, SEL_SERIAL, 0, 0, 8'h6C);
    // clear-status, then a poll read drops the stored request
    host.send(OP_CLEAR, SEL_SERIAL, 0, 0, 8'h00);
    ask(OP_READ_STATUS, SEL_MEAS, 0, 0, 8'h00);
    host.send(OP_READ_STATUS, SEL_SERIAL, 0, 0, 8'h00);
    ask(OP_READ_STATUS, SEL_SERIAL, 0, 0, 8'h00);
    chk1(srq, 1'b0);
    host.send(OP_READ_STATUS, SEL_ERR, 0, 0, 8'h00);
    ask(OP_READ_STATUS, SEL_ERR, 0, 0, 8'h00);
    // boundary crossed upward and downward
    @(posedge clk_sys_i) fhi <= 1'b1;
    ask(OP_READ_STATUS, SEL_MEAS, 0, 0, 8'h10);
    @(posedge clk_sys_i) fhi <= 1'b0;
    ask(OP_READ_STATUS, SEL_MEAS, 0, 0, 8'h10);
    // warm power-up keeps masks only while the setting is clear
    host.send(OP_WRITE_PCLR, SEL_SERIAL, 0, 0, 8'h00);
    ask(OP_READ_PCLR, SEL_SERIAL, 0, 0, 8'h00);
    chk1(pclr, 1'b0);
    pulse(SEL_STD, 7);
    ask(OP_READ_STATUS, SEL_SERIAL, 0, 0, 8'h00);
    ask(OP_READ_MASK, SEL_MEAS, 0, 0, 8'h08);
    ask(OP_READ_STATUS, SEL_STD, 0, 0, 8'h80);
    host.send(OP_WRITE_PCLR, SEL_SERIAL, 0, 0, 8'h01);
    ask(OP_READ_PCLR, SEL_SERIAL, 0, 0, 8'h01);
    pulse(SEL_STD, 7);
    ask(OP_READ_MASK, SEL_MEAS, 0, 0, 8'h00);
    ask(op_t'(3'h6), SEL_SERIAL, 0, 0, 8'h00);
    wrap_up();
  end
endmodule : status_reporting_test
